// ---- bench/ams_decoder_test.sv ----
// Purpose : self-checking bench for the addressing-mode decoder
// Assumes : memory model stalls at random when slow, bench plays the execute side
// Notes   : expectations go to a queue, a monitor compares at instrValid
module ams_decoder_test
  import ams_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // signals and tables
  typedef struct packed {
    ams_mode_t   m;
    logic [15:0] ea;
    logic [7:0]  opd;
    logic [2:0]  len;
    logic [15:0] pc;
    logic        uy;
    logic [7:0]  oc;
    logic [7:0]  pb;
    logic        hp;
    logic        bb;
    logic [15:0] bt;
  } ams_exp_t;

  // entry 16 is a bit-test-and-branch: two operand bytes, offset in the second
  localparam logic [7:0] PRE [17] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h92,
                               8'h92, 8'h92, 8'h92, 8'h91, 8'h90, 8'h00, 8'h92, 8'h92, 8'h00};
  localparam logic [7:0] OPC [17] = '{8'h40, 8'ha6, 8'hb6, 8'hc6, 8'hf6, 8'he6, 8'hd6, 8'hb6,
                               8'hc6, 8'he6, 8'hd6, 8'he6, 8'hf6, 8'h20, 8'h20, 8'ha6, 8'h00};
  localparam int LEN [17] = '{1, 2, 2, 3, 1, 2, 3, 3, 3, 3, 3, 3, 2, 2, 3, 3, 3};
  localparam ams_mode_t MODES [17] = '{AMS_MODE_INH, AMS_MODE_IMM, AMS_MODE_DIR_S,
    AMS_MODE_DIR_L, AMS_MODE_IDX0, AMS_MODE_IDX_S, AMS_MODE_IDX_L, AMS_MODE_IND_S,
    AMS_MODE_IND_L, AMS_MODE_IIX_S, AMS_MODE_IIX_L, AMS_MODE_IIX_S, AMS_MODE_IDX0,
    AMS_MODE_REL, AMS_MODE_RELIND, AMS_MODE_IMM, AMS_MODE_DIR_S};

  logic        ref_clk, resetn, memAck, memReq, execDone, pcLoad, slow;
  logic        instrValid, useY, illegalReset, pending, loadNext;
  logic [7:0]  memRdata, xReg, yReg, operand, opcode, prebyte;
  logic        hasPrebyte, bitBranch;
  logic [15:0] pcLoadValue, memAddr, effAddr, branchTarget, pcOut, nextPc;
  logic [2:0]  instrLen;
  ams_mode_t   mode;
  ams_exp_t    expQ [$];
  int          errCount, totalChecks;

  ams_decoder uut (.ref_clk(ref_clk), .resetn(resetn), .memRdata(memRdata), .memAck(memAck),
    .xReg(xReg), .yReg(yReg), .execDone(execDone), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue),
    .memReq(memReq), .memAddr(memAddr), .instrValid(instrValid), .opcode(opcode),
    .prebyte(prebyte), .hasPrebyte(hasPrebyte), .mode(mode), .useY(useY),
    .bitBranch(bitBranch), .operand(operand),
    .effAddr(effAddr), .branchTarget(branchTarget), .instrLen(instrLen), .pcOut(pcOut),
    .illegalReset(illegalReset));

  ams_mem_model mdl (.ref_clk(ref_clk), .memReq(memReq), .memAddr(memAddr), .slow(slow),
    .memAck(memAck), .memRdata(memRdata));

  always #2.5 ref_clk = ~ref_clk;

  // ==========================================================================
  // reporting
  task automatic report(input string s);
    errCount++;
    $display("[FAIL] %0t %s", $time, s);
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    totalChecks++;
    if (got !== exp) report($sformatf("%s got %h exp %h", what, got, exp));
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================================
  // monitor: one note per issued instruction
  always @(posedge ref_clk)
  begin
    if (instrValid === 1'b1 && expQ.size() == 0) report("unexpected instruction");
    else if (instrValid === 1'b1)
    begin
      ams_exp_t e;
      e = expQ.pop_front();
      cmp(16'(mode), 16'(e.m), "mode");
      cmp(effAddr, e.ea, "address");
      cmp(16'(instrLen), 16'(e.len), "length");
      cmp(pcOut, e.pc, "pc");
      cmp(16'(useY), 16'(e.uy), "y select");
      if (e.m == AMS_MODE_IMM) cmp(16'(operand), 16'(e.opd), "operand");
      if (e.m == AMS_MODE_REL || e.m == AMS_MODE_RELIND || e.bb)
        cmp(branchTarget, e.bt, "branch");
      cmp(16'(opcode), 16'(e.oc), "opcode");
      cmp(16'(hasPrebyte), 16'(e.hp), "prebyte flag");
      if (e.hp) cmp(16'(prebyte), 16'(e.pb), "prebyte");
      cmp(16'(bitBranch), 16'(e.bb), "bit branch");
    end
  end

  // ==========================================================================
  // execute side
  task automatic pulse();
    execDone    = 1'b1;
    pcLoad      = loadNext;
    pcLoadValue = loadNext ? nextPc : 16'($urandom);
    @(posedge ref_clk);
    #1;
    execDone = 1'b0;
    pcLoad   = 1'b0;
  endtask

  task automatic do_reset();
    resetn = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    cmp(memAddr, 16'h0000, "reset address");
    resetn  = 1'b1;
    pending = 1'b0;
    nextPc  = 16'h0000;
  endtask

  // places one instruction, notes the expectation, releases the previous one
  task automatic issue(input int k, input bit edgeCase);
    logic [7:0]  bb [4];
    logic [7:0]  r1, r2, p0, p1, xv, yv;
    logic [15:0] pcv;
    int          off, i;
    ams_exp_t    e;
    pcv = nextPc;
    xv  = edgeCase ? 8'hff : 8'($urandom);
    yv  = edgeCase ? 8'hff : 8'($urandom);
    r1  = (PRE[k] != 8'h00) ? 8'($urandom_range(254, 16)) : (edgeCase ? 8'hff : 8'($urandom));
    r2  = 8'($urandom);
    if (edgeCase) mdl.mem[r1] = 8'hff;
    p0  = mdl.mem[r1];
    p1  = mdl.mem[8'(r1 + 8'h01)];
    off = (PRE[k] == 8'h00) ? 1 : 0;
    bb  = '{PRE[k], OPC[k], r1, r2};
    for (i = 0; i < LEN[k]; i++) mdl.mem[pcv + 16'(i)] = bb[i + off];
    e.m   = MODES[k];
    e.opd = r1;
    e.len = 3'(LEN[k]);
    e.pc  = pcv + 16'(LEN[k]);
    e.uy  = (k == 11 || k == 12);
    case (k)
      2: e.ea = {8'h00, r1};
      3: e.ea = {r1, r2};
      4: e.ea = {8'h00, xv};
      5: e.ea = 16'(xv) + 16'(r1);
      6: e.ea = {r1, r2} + 16'(xv);
      7: e.ea = {8'h00, p0};
      8: e.ea = {p0, p1};
      9: e.ea = 16'(xv) + 16'(p0);
      10: e.ea = {p0, p1} + 16'(xv);
      11: e.ea = 16'(yv) + 16'(p0);
      12: e.ea = {8'h00, yv};
      13: e.ea = e.pc + {{8{r1[7]}}, r1};
      14: e.ea = e.pc + {{8{p0[7]}}, p0};
      16: e.ea = {8'h00, r1};
      default: e.ea = 16'h0000;
    endcase
    e.oc = OPC[k];
    e.pb = PRE[k];
    e.hp = (PRE[k] != 8'h00);
    e.bb = (k == 16);
    e.bt = (k == 16) ? e.pc + {{8{r2[7]}}, r2} : e.ea;
    expQ.push_back(e);
    xReg = xv;
    yReg = yv;
    if (pending) pulse();
    for (i = 0; i < 60 && instrValid !== 1'b1; i++)
    begin
      @(posedge ref_clk);
      #1;
    end
    if (i == 60) report("no instruction issued");
    loadNext = (pcv < 16'h1000) || ($urandom_range(1, 0) == 1);
    nextPc   = loadNext ? {4'h1, 12'($urandom)} : e.pc;
    pending  = 1'b1;
  endtask

  // ==========================================================================
  // watchdog: the whole run needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    report("watchdog expired");
    end_of_test();
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    xReg = 8'h00;
    yReg = 8'h00;
    execDone = 1'b0;
    pcLoad = 1'b0;
    pcLoadValue = 16'h0000;
    slow = 1'b0;
    loadNext = 1'b0;
    errCount = 0;
    totalChecks = 0;
    void'($urandom(32'hcd808d71));
    for (int a = 0; a < 256; a++) mdl.mem[a] = 8'($urandom);
    do_reset();
    for (int pass = 0; pass < 2; pass++)
    begin
      slow = pass[0];
      for (int k = 0; k < 15; k++) issue(k, pass == 0);
      $display("test modes pass %0d done", pass);
    end
    // undefined code: fetch stops and the flag holds
    mdl.mem[nextPc] = 8'h31;
    pulse();
    for (int i = 0; i < 20 && illegalReset !== 1'b1; i++) @(posedge ref_clk);
    repeat (8) @(posedge ref_clk);
    #1;
    cmp(16'(illegalReset), 16'h0001, "illegal code flag");
    cmp(16'(memReq), 16'h0000, "fetch halted");
    $display("test illegal code done");
    do_reset();
    issue(15, 1'b0);
    issue(16, 1'b0);
    repeat (3) @(posedge ref_clk);
    #1;
    cmp(16'(illegalReset), 16'h0000, "prebyte pairing flag");
    $display("test prebyte pairing done");
    end_of_test();
  end
endmodule

// ---- bench/ams_mem_model.sv ----
// Purpose : program memory on the far side of the decoder fetch port
// Assumes : one byte per answer, data qualified by memAck
// Notes   : slow mode stalls at random; data outside an answer is junk
module ams_mem_model
(
  input  wire logic        ref_clk,
  input  wire logic        memReq,
  input  wire logic [15:0] memAddr,
  input  wire logic        slow,
  output logic             memAck,
  output logic      [7:0]  memRdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // storage, filled by the bench
  logic [7:0] mem [65536];
  logic [7:0] junk = 8'ha5;

  // junk changes every cycle so stale data can never pass for an answer
  always @(posedge ref_clk)
  begin
    #1;
    junk   = ~junk ^ 8'h3c;
    memAck = memReq && (!slow || $urandom_range(1, 0) == 1);
  end

  assign memRdata = memAck ? mem[memAddr] : junk;
endmodule

// ---- verilog/ams_decoder.sv ----
// Purpose : instruction fetch and addressing-mode decode for an 8-bit cpu
// Assumes : memory answers each request with memAck and data together, after zero or more stall cycles
// Notes   : the execute side owns index registers and pulses execDone
module ams_decoder
  import ams_pkg::*;
#(
  parameter logic [15:0] RESET_PC = 16'h0000
)
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  memRdata,
  input  wire logic        memAck,
  input  wire logic [7:0]  xReg,
  input  wire logic [7:0]  yReg,
  input  wire logic        execDone,
  input  wire logic        pcLoad,
  input  wire logic [15:0] pcLoadValue,
  output logic             memReq,
  output logic      [15:0] memAddr,
  output logic             instrValid,
  output logic      [7:0]  opcode,
  output logic      [7:0]  prebyte,
  output logic             hasPrebyte,
  output ams_mode_t        mode,
  output logic             useY,
  output logic             bitBranch,
  output logic      [7:0]  operand,
  output logic      [15:0] effAddr,
  output logic      [15:0] branchTarget,
  output logic      [2:0]  instrLen,
  output logic      [15:0] pcOut,
  output logic             illegalReset
);

  ams_state_t state;
  logic [1:0]  nBytes;
  logic [7:0]  addrLo;
  logic [7:0]  addrHi2;
  logic [7:0]  ptrHi;
  logic [7:0]  ptrLo;
  logic        isPre;
  logic        legal;
  logic        preY;
  logic        preInd;
  logic        preIY;
  ams_mode_t   decMode;
  logic [1:0]  decBytes;
  logic        decY;
  logic        decBtj;
  logic        ptrNeeded;
  logic        ptrLong;
  logic [7:0]  idxSel;
  logic [15:0] eaCalc;
  logic [15:0] relCalc;

  // ==========================================================================
  // opcode decode
  assign isPre  = (memRdata == AMS_PRE_Y) || (memRdata == AMS_PRE_IY)
               || (memRdata == AMS_PRE_IND);
  // legality ignores the prebyte: odd pairings still run
  assign legal  = AMS_LEGAL_MAP[memRdata[7:4]][memRdata[3:0]];
  assign preY   = hasPrebyte && (prebyte == AMS_PRE_Y);
  assign preInd = hasPrebyte && (prebyte == AMS_PRE_IND);
  assign preIY  = hasPrebyte && (prebyte == AMS_PRE_IY);

  always_comb
  begin
    decMode  = AMS_MODE_INH;
    decBytes = AMS_BYTES_NONE;
    decY     = 1'b0;
    decBtj   = 1'b0;
    // every row of the map decodes
    unique case (memRdata[7:4])
      AMS_ROW_BTJ:
      begin
        decBtj   = 1'b1;
        decBytes = AMS_BYTES_TWO;
        decMode  = preInd ? AMS_MODE_IND_S : AMS_MODE_DIR_S;
      end
      AMS_ROW_BIT, AMS_ROW_RMW_DIR:
      begin
        decBytes = AMS_BYTES_ONE;
        decMode  = preInd ? AMS_MODE_IND_S : AMS_MODE_DIR_S;
      end
      AMS_ROW_REL:
      begin
        decBytes = AMS_BYTES_ONE;
        decMode  = preInd ? AMS_MODE_RELIND : AMS_MODE_REL;
      end
      AMS_ROW_RMW_A, AMS_ROW_MISC0, AMS_ROW_MISC1:
      begin
        decMode = AMS_MODE_INH;
      end
      AMS_ROW_RMW_X:
      begin
        decMode = AMS_MODE_INH;
        decY    = preY;
      end
      AMS_ROW_RMW_IXS, AMS_ROW_IDX_S:
      begin
        decBytes = AMS_BYTES_ONE;
        decMode  = (preInd || preIY) ? AMS_MODE_IIX_S : AMS_MODE_IDX_S;
        decY     = preY || preIY;
      end
      AMS_ROW_RMW_IX0, AMS_ROW_IDX0:
      begin
        decMode = AMS_MODE_IDX0;
        decY    = preY;
      end
      AMS_ROW_IMM:
      begin
        decBytes = AMS_BYTES_ONE;
        decMode  = AMS_MODE_IMM;
        decY     = preY;
      end
      AMS_ROW_DIR_S:
      begin
        decBytes = AMS_BYTES_ONE;
        decMode  = preInd ? AMS_MODE_IND_S : AMS_MODE_DIR_S;
        decY     = preY;
      end
      AMS_ROW_DIR_L:
      begin
        // long indirect keeps a one-byte pointer address
        decBytes = preInd ? AMS_BYTES_ONE : AMS_BYTES_TWO;
        decMode  = preInd ? AMS_MODE_IND_L : AMS_MODE_DIR_L;
        decY     = preY;
      end
      AMS_ROW_IDX_L:
      begin
        decBytes = (preInd || preIY) ? AMS_BYTES_ONE : AMS_BYTES_TWO;
        decMode  = (preInd || preIY) ? AMS_MODE_IIX_L : AMS_MODE_IDX_L;
        decY     = preY || preIY;
      end
    endcase
  end

  assign ptrNeeded = (mode == AMS_MODE_IND_S) || (mode == AMS_MODE_IND_L)
                  || (mode == AMS_MODE_IIX_S) || (mode == AMS_MODE_IIX_L)
                  || (mode == AMS_MODE_RELIND);
  assign ptrLong   = (mode == AMS_MODE_IND_L) || (mode == AMS_MODE_IIX_L);
  assign idxSel    = useY ? yReg : xReg;

  // ==========================================================================
  // fetch sequencer
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      state   <= AMS_S_OPC;
      pcOut   <= RESET_PC;
      memAddr <= RESET_PC;
      memReq  <= 1'b1;
    end
    else
    begin
      unique case (state)
        AMS_S_OPC:
          if (memAck)
          begin
            pcOut <= pcOut + AMS_ADDR_STEP;
            if (isPre)
              memAddr <= pcOut + AMS_ADDR_STEP;
            else if (!legal)
            begin
              state  <= AMS_S_FAULT;
              memReq <= 1'b0;
            end
            else if (decBytes != AMS_BYTES_NONE)
            begin
              state   <= AMS_S_OPND1;
              memAddr <= pcOut + AMS_ADDR_STEP;
            end
            else
            begin
              state  <= AMS_S_ISSUE;
              memReq <= 1'b0;
            end
          end
        AMS_S_OPND1:
          if (memAck)
          begin
            pcOut <= pcOut + AMS_ADDR_STEP;
            if (nBytes == AMS_BYTES_TWO)
            begin
              state   <= AMS_S_OPND2;
              memAddr <= pcOut + AMS_ADDR_STEP;
            end
            else if (ptrNeeded)
            begin
              state   <= ptrLong ? AMS_S_PTR_HI : AMS_S_PTR_LO;
              memAddr <= {AMS_ZERO_PAGE, memRdata};
            end
            else
            begin
              state  <= AMS_S_ISSUE;
              memReq <= 1'b0;
            end
          end
        AMS_S_OPND2:
          if (memAck)
          begin
            pcOut <= pcOut + AMS_ADDR_STEP;
            if (ptrNeeded)
            begin
              state   <= AMS_S_PTR_LO;
              memAddr <= {AMS_ZERO_PAGE, addrLo};
            end
            else
            begin
              state  <= AMS_S_ISSUE;
              memReq <= 1'b0;
            end
          end
        AMS_S_PTR_HI:
          if (memAck)
          begin
            state   <= AMS_S_PTR_LO;
            memAddr <= {AMS_ZERO_PAGE, addrLo} + AMS_ADDR_STEP;
          end
        AMS_S_PTR_LO:
          if (memAck)
          begin
            state  <= AMS_S_ISSUE;
            memReq <= 1'b0;
          end
        AMS_S_ISSUE:
          state <= AMS_S_EXEC;
        AMS_S_EXEC:
          if (execDone)
          begin
            state   <= AMS_S_OPC;
            memReq  <= 1'b1;
            pcOut   <= pcLoad ? pcLoadValue : pcOut;
            memAddr <= pcLoad ? pcLoadValue : pcOut;
          end
        AMS_S_FAULT:
          state <= AMS_S_FAULT;
      endcase
    end
  end

  // ==========================================================================
  // captured instruction fields
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      prebyte    <= AMS_ZERO_PAGE;
      hasPrebyte <= 1'b0;
      opcode     <= AMS_ZERO_PAGE;
      mode       <= AMS_MODE_INH;
      useY       <= 1'b0;
      bitBranch  <= 1'b0;
      nBytes     <= AMS_BYTES_NONE;
      addrLo     <= AMS_ZERO_PAGE;
      addrHi2    <= AMS_ZERO_PAGE;
      ptrHi      <= AMS_ZERO_PAGE;
      ptrLo      <= AMS_ZERO_PAGE;
    end
    else if (memAck && state == AMS_S_OPC)
    begin
      if (isPre)
      begin
        // a second prebyte replaces the first
        prebyte    <= memRdata;
        hasPrebyte <= 1'b1;
      end
      else
      begin
        opcode    <= memRdata;
        mode      <= decMode;
        useY      <= decY;
        bitBranch <= decBtj;
        nBytes    <= decBytes;
        ptrHi     <= AMS_ZERO_PAGE;  // short pointers read as zero page
      end
    end
    else if (memAck && state == AMS_S_OPND1)
      addrLo <= memRdata;
    else if (memAck && state == AMS_S_OPND2)
      addrHi2 <= memRdata;
    else if (memAck && state == AMS_S_PTR_HI)
      ptrHi <= memRdata;
    else if (memAck && state == AMS_S_PTR_LO)
      ptrLo <= memRdata;
    else if (execDone && state == AMS_S_EXEC)
      hasPrebyte <= 1'b0;
  end

  // ==========================================================================
  // address arithmetic
  ams_ea_calc u_ea (
    .mode      (mode),
    .bitBranch (bitBranch),
    .addrLo    (addrLo),
    .addrHi2   (addrHi2),
    .ptrHi     (ptrHi),
    .ptrLo     (ptrLo),
    .idx       (idxSel),
    .pcNext    (pcOut),
    .effAddr   (eaCalc),
    .relTarget (relCalc)
  );

  // ==========================================================================
  // issue to execute
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      instrValid   <= 1'b0;
      operand      <= AMS_ZERO_PAGE;
      effAddr      <= AMS_ADDR_NONE;
      branchTarget <= AMS_ADDR_NONE;
      instrLen     <= AMS_LEN_OPC;
    end
    else
    begin
      instrValid <= (state == AMS_S_ISSUE);
      if (state == AMS_S_ISSUE)
      begin
        operand      <= addrLo;
        effAddr      <= eaCalc;
        branchTarget <= relCalc;
        instrLen     <= {2'b00, hasPrebyte} + AMS_LEN_OPC + {1'b0, nBytes};
      end
    end
  end

  // ==========================================================================
  // illegal code fault; held until the system reset lands
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      illegalReset <= 1'b0;
    else if (state == AMS_S_OPC && memAck && !isPre && !legal)
      illegalReset <= 1'b1;
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence illegalSeen;
    state == AMS_S_OPC && memAck && !isPre && !legal;
  endsequence

  sequence resumeFetch;
    state == AMS_S_EXEC && execDone && !pcLoad;
  endsequence

  len_range_a: assert property (instrValid |-> instrLen >= AMS_LEN_OPC
    && instrLen <= AMS_LEN_MAX) else $error("length out of range");
  inherent_len_a: assert property (instrValid && mode == AMS_MODE_INH |->
    instrLen == {2'b00, hasPrebyte} + AMS_LEN_OPC)
    else $error("inherent length wrong");
  imm_len_a: assert property (instrValid && mode == AMS_MODE_IMM && !hasPrebyte |->
    instrLen == 3'h2) else $error("immediate length wrong");
  short_dir_a: assert property (instrValid && mode == AMS_MODE_DIR_S |->
    effAddr == {AMS_ZERO_PAGE, addrLo}) else $error("short direct address wrong");
  idx_short_a: assert property (state == AMS_S_ISSUE && mode == AMS_MODE_IDX_S |=>
    effAddr == {AMS_ZERO_PAGE, $past(idxSel)} + {AMS_ZERO_PAGE, addrLo})
    else $error("short indexed sum wrong");
  rel_target_a: assert property (instrValid && mode == AMS_MODE_REL |->
    branchTarget == pcOut + {{8{addrLo[7]}}, addrLo})
    else $error("relative target wrong");
  illegal_hold_a: assert property (illegalSeen |=> (illegalReset && !memReq) [*3])
    else $error("illegal code not trapped");
  pre_no_fault_a: assert property (state == AMS_S_OPC && memAck && hasPrebyte
    && !isPre && legal |=> !illegalReset) else $error("prebyte pair faulted");
  next_fetch_a: assert property (resumeFetch |=> memReq && memAddr == pcOut
    && state == AMS_S_OPC) else $error("next fetch address wrong");
  operand_step_a: assert property (state == AMS_S_OPND1 && memAck |=>
    pcOut == $past(pcOut) + AMS_ADDR_STEP) else $error("pc did not step");

endmodule

// ---- verilog/ams_ea_calc.sv ----
// Purpose : effective address and relative target arithmetic
// Assumes : all inputs stable in the issue cycle
// Notes   : purely combinational; the caller registers the results
module ams_ea_calc
  import ams_pkg::*;
(
  input  wire ams_mode_t   mode,
  input  wire logic        bitBranch,
  input  wire logic [7:0]  addrLo,
  input  wire logic [7:0]  addrHi2,
  input  wire logic [7:0]  ptrHi,
  input  wire logic [7:0]  ptrLo,
  input  wire logic [7:0]  idx,
  input  wire logic [15:0] pcNext,
  output logic      [15:0] effAddr,
  output logic      [15:0] relTarget
);

  logic [7:0] relOffset;

  // ==========================================================================
  // relative target
  always_comb
  begin
    if (mode == AMS_MODE_RELIND)
      relOffset = ptrLo;
    else if (bitBranch)
      relOffset = addrHi2;
    else
      relOffset = addrLo;
    // pc already points past the whole instruction
    relTarget = pcNext + {{8{relOffset[7]}}, relOffset};
  end

  // ==========================================================================
  // effective address
  always_comb
  begin
    unique case (mode)
      AMS_MODE_DIR_S:  effAddr = {AMS_ZERO_PAGE, addrLo};
      AMS_MODE_DIR_L:  effAddr = {addrLo, addrHi2};
      AMS_MODE_IDX0:   effAddr = {AMS_ZERO_PAGE, idx};
      AMS_MODE_IDX_S:  effAddr = {AMS_ZERO_PAGE, idx} + {AMS_ZERO_PAGE, addrLo};
      AMS_MODE_IDX_L:  effAddr = {addrLo, addrHi2} + {AMS_ZERO_PAGE, idx};
      AMS_MODE_IND_S:  effAddr = {AMS_ZERO_PAGE, ptrLo};
      AMS_MODE_IND_L:  effAddr = {ptrHi, ptrLo};
      AMS_MODE_IIX_S:  effAddr = {AMS_ZERO_PAGE, ptrLo} + {AMS_ZERO_PAGE, idx};
      AMS_MODE_IIX_L:  effAddr = {ptrHi, ptrLo} + {AMS_ZERO_PAGE, idx};
      AMS_MODE_REL,
      AMS_MODE_RELIND: effAddr = relTarget;
      AMS_MODE_INH,
      AMS_MODE_IMM:    effAddr = AMS_ADDR_NONE;
      default:         effAddr = AMS_ADDR_NONE;
    endcase
  end

endmodule

// ---- verilog/ams_pkg.sv ----
// Purpose : shared constants and types for the addressing-mode decoder
// Assumes : one clock, 16-bit address space, 8-bit program memory
// Notes   : opcode row map and legality masks are this design's own layout
package ams_pkg;

  // ==========================================================================
  // prebyte codes
  localparam logic [7:0] AMS_PRE_Y   = 8'h90;
  localparam logic [7:0] AMS_PRE_IY  = 8'h91;
  localparam logic [7:0] AMS_PRE_IND = 8'h92;

  // ==========================================================================
  // addressing modes
  typedef enum logic [3:0] {
    AMS_MODE_INH    = 4'h0,
    AMS_MODE_IMM    = 4'h1,
    AMS_MODE_DIR_S  = 4'h2,
    AMS_MODE_DIR_L  = 4'h3,
    AMS_MODE_IDX0   = 4'h4,
    AMS_MODE_IDX_S  = 4'h5,
    AMS_MODE_IDX_L  = 4'h6,
    AMS_MODE_IND_S  = 4'h7,
    AMS_MODE_IND_L  = 4'h8,
    AMS_MODE_IIX_S  = 4'h9,
    AMS_MODE_IIX_L  = 4'ha,
    AMS_MODE_REL    = 4'hb,
    AMS_MODE_RELIND = 4'hc
  } ams_mode_t;

  // ==========================================================================
  // fetch sequencer states
  typedef enum logic [2:0] {
    AMS_S_OPC    = 3'h0,
    AMS_S_OPND1  = 3'h1,
    AMS_S_OPND2  = 3'h2,
    AMS_S_PTR_HI = 3'h3,
    AMS_S_PTR_LO = 3'h4,
    AMS_S_ISSUE  = 3'h5,
    AMS_S_EXEC   = 3'h6,
    AMS_S_FAULT  = 3'h7
  } ams_state_t;

  // ==========================================================================
  // opcode rows (high nibble)
  localparam logic [3:0] AMS_ROW_BTJ     = 4'h0;
  localparam logic [3:0] AMS_ROW_BIT     = 4'h1;
  localparam logic [3:0] AMS_ROW_REL     = 4'h2;
  localparam logic [3:0] AMS_ROW_RMW_DIR = 4'h3;
  localparam logic [3:0] AMS_ROW_RMW_A   = 4'h4;
  localparam logic [3:0] AMS_ROW_RMW_X   = 4'h5;
  localparam logic [3:0] AMS_ROW_RMW_IXS = 4'h6;
  localparam logic [3:0] AMS_ROW_RMW_IX0 = 4'h7;
  localparam logic [3:0] AMS_ROW_MISC0   = 4'h8;
  localparam logic [3:0] AMS_ROW_MISC1   = 4'h9;
  localparam logic [3:0] AMS_ROW_IMM     = 4'ha;
  localparam logic [3:0] AMS_ROW_DIR_S   = 4'hb;
  localparam logic [3:0] AMS_ROW_DIR_L   = 4'hc;
  localparam logic [3:0] AMS_ROW_IDX_L   = 4'hd;
  localparam logic [3:0] AMS_ROW_IDX_S   = 4'he;
  localparam logic [3:0] AMS_ROW_IDX0    = 4'hf;

  // one bit per low nibble: set means a defined opcode
  localparam logic [15:0] AMS_LEGAL_MAP [16] = '{
    16'hffff, 16'hffff, 16'hffff, 16'hb7d9,
    16'hb7dd, 16'hb7d9, 16'hb7d9, 16'hb7d9,
    16'hcf3b, 16'hbff8, 16'hfbff, 16'hffff,
    16'hffff, 16'hffff, 16'hffff, 16'hffff
  };

  // ==========================================================================
  // byte counts and address constants
  localparam logic [1:0]  AMS_BYTES_NONE = 2'h0;
  localparam logic [1:0]  AMS_BYTES_ONE  = 2'h1;
  localparam logic [1:0]  AMS_BYTES_TWO  = 2'h2;
  localparam logic [2:0]  AMS_LEN_OPC    = 3'h1;
  localparam logic [2:0]  AMS_LEN_MAX    = 3'h4;
  localparam logic [7:0]  AMS_ZERO_PAGE  = 8'h00;
  localparam logic [15:0] AMS_ADDR_NONE  = 16'h0000;
  localparam logic [15:0] AMS_ADDR_STEP  = 16'h0001;

endpackage
